// *** sw_event_irq.sv ***
// Software event interrupt raw, status and mask logic with APB registers
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module sw_event_irq
   import sw_irq_pkg::*;
#(
   parameter int HW_W = 4
) (
   input  wire logic              i_core_clk,
   input  wire logic              i_sys_rst,
   // APB slave
   input  wire logic              i_psel,
   input  wire logic              i_penable,
   input  wire logic              i_pwrite,
   input  wire logic [ADDR_W-1:0] i_paddr,
   input  wire logic [31:0]       i_pwdata,
   output logic      [31:0]       o_prdata,
   output logic                   o_pready,
   output logic                   o_pslverr,
   // Event pulses from the embedded controller
   input  wire logic              i_antenna_rx_complete,
   input  wire logic              i_antenna_tx_complete,
   input  wire logic              i_antenna_rx_timeout,
   input  wire logic              i_tuner_xfer_error,
   input  wire logic              i_tuner_xfer_done,
   // Hardware interrupt group, already sticky elsewhere
   input  wire logic [HW_W-1:0]   i_hw_irq_status,
   output logic                   o_host_irq_out
);
   typedef struct packed {
      logic [7:0]      raw;
      logic [7:0]      mask;
      logic [HW_W-1:0] hw_en;
      logic [31:0]     prdata;
      logic            pslverr;
      logic            irq;
   } irq_s;

   irq_s state_ff;
   irq_s nxt_state;

   logic            acc;
   logic            wr;
   logic            hit;
   logic [7:0]      idx;
   logic [4:0]      ev_rise;
   logic [HW_W-1:0] hw_lvl;
   logic [7:0]      ev_vec;
   logic [7:0]      clr_vec;
   logic [7:0]      status;
   logic [7:0]      wr_byte;
   logic [7:0]      keep_vec;
   logic            setup;
   logic            irq_cond;

   sw_irq_apb u_apb (
      .i_core_clk (i_core_clk),
      .i_sys_rst  (i_sys_rst),
      .i_psel     (i_psel),
      .i_penable  (i_penable),
      .i_pwrite   (i_pwrite),
      .i_paddr    (i_paddr),
      .o_acc      (acc),
      .o_wr       (wr),
      .o_hit      (hit),
      .o_idx      (idx)
   );

   // Controller events come from another block; treated as asynchronous
   sw_irq_sync #(.W(5)) u_ev_sync (
      .i_core_clk (i_core_clk),
      .i_sys_rst  (i_sys_rst),
      .i_async    ({i_antenna_rx_complete, i_antenna_tx_complete, i_antenna_rx_timeout,
                    i_tuner_xfer_error, i_tuner_xfer_done}),
      .o_rise     (ev_rise)
   );

   assign hw_lvl = i_hw_irq_status;

   // Place synchronised events into register layout
   always_comb begin
      ev_vec                 = 8'h00;
      ev_vec[BIT_RX_DONE]    = ev_rise[4];
      ev_vec[BIT_TX_DONE]    = ev_rise[3];
      ev_vec[BIT_RX_TMO]     = ev_rise[2];
      ev_vec[BIT_TUNER_ERR]  = ev_rise[1];
      ev_vec[BIT_TUNER_DONE] = ev_rise[0] & ~ev_rise[1];
   end

   // Write-one-to-clear strobe; never stored, so it reads back as zero
   assign wr_byte = i_pwdata[7:0];
   assign clr_vec = (wr && hit && idx == CLEAR_IDX) ? (wr_byte & EVENT_BITS) : 8'h00;

   // Status is combinational from raw and mask, so clearing raw clears it too
   assign status = state_ff.raw & state_ff.mask & EVENT_BITS;
   assign irq_cond = (|status) | (|(hw_lvl & state_ff.hw_en));

   // Setup phase for read mux and checks; surviving raw bits for checks only
   assign setup    = i_psel & ~i_penable;
   assign keep_vec = state_ff.raw & ~clr_vec;

   // Mapped register test; misaligned addresses never hit a register
   function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
      logic [7:0] ix;
      ix         = a[ADDR_W-1:2];
      reg_mapped = (a[1:0] == 2'b00) &&
                   (ix == RAW_IDX || ix == STATUS_IDX || ix == MASK_IDX ||
                    ix == CLEAR_IDX || ix == HW_IRQ_EN_IDX || ix == HW_IRQ_STS_IDX);
   endfunction : reg_mapped

   // Register update and read mux
   always_comb begin
      nxt_state         = state_ff;
      // Set wins over clear so an event in the clearing cycle is kept
      nxt_state.raw     = ((state_ff.raw & ~clr_vec) | ev_vec) & EVENT_BITS;
      nxt_state.pslverr = 1'b0;
      nxt_state.prdata  = 32'h0000_0000;
      if (wr && hit && idx == MASK_IDX) begin
         nxt_state.mask = wr_byte & EVENT_BITS;
      end
      if (wr && hit && idx == HW_IRQ_EN_IDX) begin
         nxt_state.hw_en = i_pwdata[HW_W-1:0];
      end
      if (setup) begin
         // Read data prepared in setup phase, presented in access phase
         unique case (i_paddr[ADDR_W-1:2])
            RAW_IDX:        nxt_state.prdata = {24'h000000, state_ff.raw};
            STATUS_IDX:     nxt_state.prdata = {24'h000000, status};
            MASK_IDX:       nxt_state.prdata = {24'h000000, state_ff.mask};
            HW_IRQ_EN_IDX:  nxt_state.prdata = {{(32-HW_W){1'b0}}, state_ff.hw_en};
            HW_IRQ_STS_IDX: nxt_state.prdata = {{(32-HW_W){1'b0}}, hw_lvl};
            default:        nxt_state.prdata = 32'h0000_0000;
         endcase
         nxt_state.pslverr = !reg_mapped(i_paddr);
      end
      // Registered level, one cycle behind the status it reflects
      nxt_state.irq = irq_cond;
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         state_ff.raw     <= RESET_RAW;
         state_ff.mask    <= RESET_MASK;
         state_ff.hw_en   <= '0;
         state_ff.prdata  <= 32'h0000_0000;
         state_ff.pslverr <= 1'b0;
         state_ff.irq     <= 1'b0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Zero wait state slave; pready tied high, other outputs straight from flip-flops
   assign o_prdata       = state_ff.prdata;
   assign o_pslverr      = state_ff.pslverr; // Set at setup, cleared at access edge
   assign o_pready       = 1'b1;
   assign o_host_irq_out = state_ff.irq;

   property p_status_and;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (setup && i_paddr == reg_addr(STATUS_IDX)) |=>
         (o_prdata == {24'h000000, $past(state_ff.raw) & $past(state_ff.mask)});
   endproperty
   a_status_and: assert property (p_status_and)
      else $error("Status is not raw AND mask");

   property p_raw_clr_status;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (clr_vec[BIT_RX_TMO] && !ev_vec[BIT_RX_TMO]) |=> !status[BIT_RX_TMO];
   endproperty
   a_raw_clr_status: assert property (p_raw_clr_status)
      else $error("Status bit survived raw clear");

   property p_irq_set;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (|status) |=> o_host_irq_out;
   endproperty
   a_irq_set: assert property (p_irq_set)
      else $error("Interrupt missing for unmasked status");

   property p_irq_hw;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (|(hw_lvl & state_ff.hw_en)) |=> o_host_irq_out;
   endproperty
   a_irq_hw: assert property (p_irq_hw)
      else $error("Interrupt missing for hardware source");

   property p_rx_done;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      ev_rise[4] |=> state_ff.raw[5];
   endproperty
   a_rx_done: assert property (p_rx_done)
      else $error("Receive complete not recorded");

   property p_tx_done;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (ev_rise[3] && state_ff.mask[4] && !(wr && hit && idx == MASK_IDX)) |=> status[4];
   endproperty
   a_tx_done: assert property (p_tx_done)
      else $error("Transmit complete status not set");

   property p_rx_tmo;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (ev_rise[2] && state_ff.mask[3] && !(wr && hit && idx == MASK_IDX)) |=> status[3];
   endproperty
   a_rx_tmo: assert property (p_rx_tmo)
      else $error("Receive timeout status not set");

   property p_tuner_err;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      ev_rise[1] |=> state_ff.raw[1];
   endproperty
   a_tuner_err: assert property (p_tuner_err)
      else $error("Tuner error not recorded");

   property p_tuner_done_err;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (ev_rise[1] && ev_rise[0] && !state_ff.raw[0]) |=> !state_ff.raw[0];
   endproperty
   a_tuner_done_err: assert property (p_tuner_done_err)
      else $error("Tuner done set together with error");

   property p_masked;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (state_ff.mask == 8'h00 && hw_lvl == '0) ##1 (state_ff.mask == 8'h00 && hw_lvl == '0)
         |=> !o_host_irq_out;
   endproperty
   a_masked: assert property (p_masked)
      else $error("Masked event raised interrupt");

   property p_reserved;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (state_ff.raw[7:6] == 2'b00) && !state_ff.raw[2] && (state_ff.mask & 8'hc4) == 8'h00;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("Reserved bit set");

   property p_irq_drop;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (status == 8'h00 && (hw_lvl & state_ff.hw_en) == '0) |=> !o_host_irq_out;
   endproperty
   a_irq_drop: assert property (p_irq_drop)
      else $error("Interrupt stuck after clear");

   property p_rx_done_sts;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (ev_rise[4] && state_ff.mask[5] && !(wr && hit && idx == MASK_IDX)) |=> status[5];
   endproperty
   a_rx_done_sts: assert property (p_rx_done_sts)
      else $error("Receive complete status not set");

   property p_tuner_err_sts;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (ev_rise[1] && state_ff.mask[1] && !(wr && hit && idx == MASK_IDX)) |=> status[1];
   endproperty
   a_tuner_err_sts: assert property (p_tuner_err_sts)
      else $error("Tuner error status not set");

   property p_tuner_done;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (ev_rise[0] && !ev_rise[1]) |=> state_ff.raw[0];
   endproperty
   a_tuner_done: assert property (p_tuner_done)
      else $error("Tuner done not recorded");

   property p_raw_sticky;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (keep_vec != 8'h00) |=> ((state_ff.raw & $past(keep_vec)) == $past(keep_vec));
   endproperty
   a_raw_sticky: assert property (p_raw_sticky)
      else $error("Raw bit lost without clear");

   property p_raw_read;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (setup && i_paddr == reg_addr(RAW_IDX)) |=>
         (o_prdata == {24'h000000, $past(state_ff.raw)});
   endproperty
   a_raw_read: assert property (p_raw_read)
      else $error("Raw read data wrong");

   property p_raw_clear;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (clr_vec != 8'h00) |=> ((state_ff.raw & $past(clr_vec) & ~$past(ev_vec)) == 8'h00);
   endproperty
   a_raw_clear: assert property (p_raw_clear)
      else $error("Raw bit survived clear");

   property p_clear_reads_zero;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (setup && i_paddr == reg_addr(CLEAR_IDX)) |=> (o_prdata == 32'h0000_0000);
   endproperty
   a_clear_reads_zero: assert property (p_clear_reads_zero)
      else $error("Clear register read not zero");

   property p_mask_write;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (wr && hit && idx == MASK_IDX) |=> (state_ff.mask == ($past(wr_byte) & EVENT_BITS));
   endproperty
   a_mask_write: assert property (p_mask_write)
      else $error("Mask write not stored");

   property p_mask_hold;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      !(wr && hit && idx == MASK_IDX) |=> $stable(state_ff.mask);
   endproperty
   a_mask_hold: assert property (p_mask_hold)
      else $error("Mask changed without write");

   property p_reserved_read;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (setup && (i_paddr == reg_addr(STATUS_IDX) || i_paddr == reg_addr(MASK_IDX) ||
                 i_paddr == reg_addr(RAW_IDX))) |=> ((o_prdata & 32'hffff_ffc4) == 32'h0000_0000);
   endproperty
   a_reserved_read: assert property (p_reserved_read)
      else $error("Reserved bit read as one");

   property p_irq_level;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      o_host_irq_out |-> $past(irq_cond);
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("Interrupt high without cause");

   property p_slverr_access;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      o_pslverr |-> acc;
   endproperty
   a_slverr_access: assert property (p_slverr_access)
      else $error("Error flag outside access phase");
endmodule : sw_event_irq
`default_nettype wire

// *** sw_event_irq_test.sv ***
// Register level testbench of the event interrupt block
`timescale 1ns/1ps
`default_nettype none
module sw_event_irq_test
   import sw_irq_pkg::*;
;
   logic              i_core_clk = 1'b0;
   logic              i_sys_rst  = 1'b1;
   logic              psel       = 1'b0;
   logic              penable    = 1'b0;
   logic              pwrite     = 1'b0;
   logic [ADDR_W-1:0] paddr      = '0;
   logic [31:0]       pwdata     = 32'h00000000;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic              go         = 1'b0;
   logic [4:0]        sel        = 5'h00;
   logic [4:0]        evt;
   logic [3:0]        hw         = 4'h0;
   logic              irq;
   logic              last_err;
   logic [31:0]       rdv;
   int                fail_count = 0;
   int                n_checks   = 0;
   // Status bit of each event line, line 0 up to line 4
   int                pos [5]    = '{0, 1, 3, 4, 5};

   always #50 i_core_clk = ~i_core_clk;

   sw_event_source u_sw_event_source (
      .i_core_clk (i_core_clk), .i_go (go), .i_sel (sel), .o_evt (evt));

   sw_event_irq #(.HW_W(4)) u_sw_event_irq (
      .i_core_clk (i_core_clk), .i_sys_rst (i_sys_rst),
      .i_psel (psel), .i_penable (penable), .i_pwrite (pwrite), .i_paddr (paddr),
      .i_pwdata (pwdata), .o_prdata (prdata), .o_pready (pready), .o_pslverr (pslverr),
      .i_antenna_rx_complete (evt[4]), .i_antenna_tx_complete (evt[3]),
      .i_antenna_rx_timeout (evt[2]), .i_tuner_xfer_error (evt[1]),
      .i_tuner_xfer_done (evt[0]), .i_hw_irq_status (hw), .o_host_irq_out (irq));

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
      end
   endtask : chk

   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      @(posedge i_core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= {24'h000000, wd};
      @(posedge i_core_clk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge i_core_clk);
         if (pready === 1'b1) break;
      end
      if (n == 16) begin
         fail_count++;
         test_done();
      end
      rdv      = prdata;
      last_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input string msg);
      apb(1'b0, idx, 8'h00);
      chk(rdv, {24'h000000, exp}, msg);
   endtask : rd_chk

   // Irq is registered: let two edges land before looking; return on a rising edge
   task automatic irq_chk(input logic exp);
      repeat (2) @(posedge i_core_clk);
      @(negedge i_core_clk);
      chk({31'h0, irq}, {31'h0, exp}, "irq level");
      @(posedge i_core_clk);
   endtask : irq_chk

   // Hold long enough for synchroniser plus raw and irq latency
   task automatic fire(input logic [4:0] s);
      @(posedge i_core_clk);
      go  <= 1'b1;
      sel <= s;
      @(posedge i_core_clk);
      go  <= 1'b0;
      repeat (12) @(posedge i_core_clk);
   endtask : fire

   initial begin
      repeat (20000) @(posedge i_core_clk);
      fail_count++;
      test_done();
   end

   initial begin
      logic [7:0] b;
      repeat (3) @(posedge i_core_clk);
      i_sys_rst <= 1'b0;
      rd_chk(RAW_IDX, 8'h00, "raw reset");
      rd_chk(STATUS_IDX, 8'h00, "status reset");
      rd_chk(MASK_IDX, 8'h00, "mask reset");
      irq_chk(1'b0);
      $display("test reset values done");
      // Each event masked first, then unmasked, then cleared by the host
      for (int i = 0; i < 5; i++) begin
         b = 8'h01 << pos[i];
         fire(5'h01 << i);
         rd_chk(RAW_IDX, b, "raw while masked");
         rd_chk(STATUS_IDX, 8'h00, "status while masked");
         irq_chk(1'b0);
         apb(1'b1, MASK_IDX, b);
         rd_chk(MASK_IDX, b, "mask readback");
         chk({31'h0, last_err}, 32'h00000000, "mapped access error");
         rd_chk(STATUS_IDX, b, "status unmasked");
         irq_chk(1'b1);
         apb(1'b1, CLEAR_IDX, b);
         rd_chk(RAW_IDX, 8'h00, "raw after clear");
         rd_chk(STATUS_IDX, 8'h00, "status after clear");
         irq_chk(1'b0);
         rd_chk(CLEAR_IDX, 8'h00, "clear self resets");
         apb(1'b1, MASK_IDX, 8'h00);
      end
      $display("test single events done");
      // Done and error together: only the error may stand
      apb(1'b1, MASK_IDX, 8'hff);
      rd_chk(MASK_IDX, 8'h3b, "mask spare bits");
      fire(5'h03);
      rd_chk(RAW_IDX, 8'h02, "done suppressed by error");
      rd_chk(STATUS_IDX, 8'h02, "error status");
      irq_chk(1'b1);
      apb(1'b1, MASK_IDX, 8'h00);
      rd_chk(STATUS_IDX, 8'h00, "status follows mask");
      irq_chk(1'b0);
      apb(1'b1, CLEAR_IDX, 8'hff);
      rd_chk(RAW_IDX, 8'h00, "raw cleared");
      $display("test done with error done");
      // Hardware group joins the same request line
      hw <= 4'h2;
      apb(1'b1, HW_IRQ_EN_IDX, 8'h02);
      rd_chk(HW_IRQ_STS_IDX, 8'h02, "hw status");
      rd_chk(HW_IRQ_EN_IDX, 8'h02, "hw enable readback");
      irq_chk(1'b1);
      hw <= 4'h0;
      irq_chk(1'b0);
      apb(1'b1, HW_IRQ_EN_IDX, 8'h00);
      $display("test hardware group done");
      // Unmapped index refused with error and zero data
      rd_chk(8'h00, 8'h00, "unmapped read data");
      chk({31'h0, last_err}, 32'h00000001, "unmapped error");
      apb(1'b1, 8'h00, 8'h5a);
      chk({31'h0, last_err}, 32'h00000001, "unmapped write error");
      $display("test unmapped access done");
      test_done();
   end
endmodule : sw_event_irq_test
`default_nettype wire

// *** sw_event_source.sv ***
// Embedded controller model that raises event lines towards the block
`timescale 1ns/1ps
`default_nettype none
module sw_event_source #(
   parameter int HOLD = 4
) (
   input  wire logic       i_core_clk,
   input  wire logic       i_go,
   input  wire logic [4:0] i_sel,
   output logic      [4:0] o_evt
);
   int unsigned cnt = 0;

   initial o_evt = 5'h00;

   // Level held past the three-flop filter, then dropped to idle low
   always @(posedge i_core_clk) begin
      if (i_go) begin
         o_evt <= i_sel;
         cnt   <= HOLD;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end else begin
         o_evt <= 5'h00;
         cnt   <= 0;
      end
   end
endmodule : sw_event_source
`default_nettype wire

// *** sw_irq_apb.sv ***
// APB slave front end: decodes one completed access into strobes
`timescale 1ns/1ps
`default_nettype none
module sw_irq_apb
   import sw_irq_pkg::*;
(
   input  wire logic              i_core_clk,
   input  wire logic              i_sys_rst,
   input  wire logic              i_psel,
   input  wire logic              i_penable,
   input  wire logic              i_pwrite,
   input  wire logic [ADDR_W-1:0] i_paddr,
   output logic                   o_acc,
   output logic                   o_wr,
   output logic                   o_hit,
   output logic      [7:0]        o_idx
);
   typedef struct packed {
      logic dummy;
   } apb_s;

   apb_s state_ff;
   apb_s nxt_state;

   // Zero wait states: access phase completes in its first cycle
   always_comb begin
      nxt_state       = state_ff;
      nxt_state.dummy = i_psel & ~i_penable;
      o_acc           = i_psel & i_penable;
      o_wr            = i_psel & i_penable & i_pwrite;
      o_idx           = i_paddr[ADDR_W-1:2];
      o_hit           = (i_paddr[1:0] == 2'b00) &&
                        (o_idx == RAW_IDX || o_idx == STATUS_IDX || o_idx == MASK_IDX ||
                         o_idx == CLEAR_IDX || o_idx == HW_IRQ_EN_IDX ||
                         o_idx == HW_IRQ_STS_IDX);
   end

   // Setup-phase tracker, kept only for the access-order check below
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   property p_apb_setup_first;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      $rose(i_penable) |-> state_ff.dummy;
   endproperty
   a_apb_setup_first: assert property (p_apb_setup_first)
      else $error("Access phase without setup phase");
endmodule : sw_irq_apb
`default_nettype wire

// *** sw_irq_pkg.sv ***
// Package with register map, field positions and reset values of the event interrupt block
package sw_irq_pkg;

   // Printed offsets are not multiples of four: each is a register index, byte address is 4x
   localparam logic [7:0]  RAW_IDX        = 8'hf9;
   localparam logic [7:0]  STATUS_IDX     = 8'hfb;
   localparam logic [7:0]  MASK_IDX       = 8'hfd;
   localparam logic [7:0]  CLEAR_IDX      = 8'hff;
   localparam logic [7:0]  HW_IRQ_EN_IDX  = 8'hf0;
   localparam logic [7:0]  HW_IRQ_STS_IDX = 8'hf1;

   localparam int          ADDR_W         = 10;

   // Event bit positions
   localparam int          BIT_RX_DONE    = 5;
   localparam int          BIT_TX_DONE    = 4;
   localparam int          BIT_RX_TMO     = 3;
   localparam int          BIT_TUNER_ERR  = 1;
   localparam int          BIT_TUNER_DONE = 0;

   // Implemented bits; 7:6 and 2 carry no function
   localparam logic [7:0]  EVENT_BITS     = 8'h3b;
   localparam logic [7:0]  RESET_RAW      = 8'h00;
   localparam logic [7:0]  RESET_MASK     = 8'h00;
   localparam logic [7:0]  RESET_HW_EN    = 8'h00;

   // Antenna receive timeout, kept for reference by the timer owner
   localparam int          RX_TMO_MS      = 100;
   localparam int          CLK_HZ         = 10_000_000;
   localparam int          RX_TMO_CYC     = RX_TMO_MS * (CLK_HZ / 1000);

   // Byte address of a register index
   function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
      reg_addr = {idx, 2'b00};
   endfunction : reg_addr

endpackage : sw_irq_pkg

// *** sw_irq_sync.sv ***
// Three-stage synchroniser with agreement filter for event pulses from outside
`timescale 1ns/1ps
`default_nettype none
module sw_irq_sync #(
   parameter int W = 5
) (
   input  wire logic         i_core_clk,
   input  wire logic         i_sys_rst,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_rise
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
      logic [W-1:0] rise;
   } sync_s;

   sync_s state_ff;
   sync_s nxt_state;

   // Only s2 and s3 are compared; s1 feeds s2 alone to limit metastability
   always_comb begin
      nxt_state      = state_ff;
      nxt_state.s1   = i_async;
      nxt_state.s2   = state_ff.s1;
      nxt_state.s3   = state_ff.s2;
      for (int i = 0; i < W; i++) begin
         if (state_ff.s2[i] == state_ff.s3[i]) begin
            nxt_state.lvl[i] = state_ff.s3[i];
         end
      end
      nxt_state.rise = nxt_state.lvl & ~state_ff.lvl;
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign o_rise = state_ff.rise;
endmodule : sw_irq_sync
`default_nettype wire
